// >>> src/dmae_pkg.sv
package dmae_pkg;
  localparam int          NCH           = 32;
  localparam logic [4:0]  SW_CH         = 5'h1E;
  localparam int          TBL_LSB       = 10;
  // APB register offsets
  localparam logic [11:0] OFF_CFG       = 12'h000;
  localparam logic [11:0] OFF_BASE      = 12'h004;
  localparam logic [11:0] OFF_ENA_SET   = 12'h008;
  localparam logic [11:0] OFF_ENA_CLR   = 12'h00C;
  localparam logic [11:0] OFF_SWREQ     = 12'h010;
  localparam logic [11:0] OFF_PRIO      = 12'h014;
  localparam logic [11:0] OFF_REQMASK   = 12'h018;
  localparam logic [11:0] OFF_BURST     = 12'h01C;
  localparam logic [11:0] OFF_ALTSEL    = 12'h020;
  localparam logic [11:0] OFF_ERR       = 12'h024;
  localparam logic [11:0] OFF_STAT      = 12'h028;
  // Control word fields of a channel structure, and the channel field of the status register
  localparam int          CTL_MODE_LSB  = 0;
  localparam int          CTL_CNT_LSB   = 4;
  localparam int          CTL_SIZE_LSB  = 16;
  localparam int          CTL_SINC_LSB  = 18;
  localparam int          CTL_DINC_LSB  = 20;
  localparam int          STAT_CH_LSB   = 1;
  // Structure word indexes
  localparam logic [1:0]  W_SRC         = 2'h0;
  localparam logic [1:0]  W_DST         = 2'h1;
  localparam logic [1:0]  W_CTL         = 2'h2;
  // Modes
  localparam logic [2:0]  M_STOP        = 3'h0;
  localparam logic [2:0]  M_BASIC       = 3'h1;
  localparam logic [2:0]  M_AUTO        = 3'h2;
  localparam logic [2:0]  M_PINGPONG    = 3'h3;
  localparam logic [2:0]  M_MSG         = 3'h4;
  localparam logic [2:0]  M_MSG_ALT     = 3'h5;
  localparam logic [2:0]  M_PSG         = 3'h6;
  localparam logic [2:0]  M_PSG_ALT     = 3'h7;
  // Item sizes, address steps and the last item index of a task copy
  localparam logic [1:0]  SZ_WORD       = 2'h2;
  localparam logic [1:0]  INC_WORD      = 2'h2;
  localparam logic [1:0]  INC_NONE      = 2'h3;
  localparam logic [1:0]  SG_LAST_ITEM  = 2'h3;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0, S_LDSRC = 4'h1, S_LDDST = 4'h3, S_LDCTL = 4'h2,
    S_RDIT  = 4'h6, S_WRIT  = 4'h7, S_WBSRC = 4'h5, S_WBDST = 4'h4,
    S_WBCTL = 4'hC, S_FIN   = 4'hD
  } dmae_state_e;
endpackage

// >>> src/dmae_engine.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// What this block does
// RULE_01: Items are 8, 16 or 32 bits, chosen per channel in its control word.
// RULE_02: After each item source and destination step by byte, half, word or none.
// RULE_03: Two priority levels, set per channel, decide among pending channels.
// RULE_04: The engine starts no memory access while the processor uses the bus.
// RULE_05: Each direction has its own channel; one channel is kept for software.
// RULE_06: Software can request a transfer on any channel.
// RULE_07: Basic mode moves items only while the request stays high.
// RULE_08: Auto mode runs to the last item once started.
// RULE_09: Ping-pong swaps primary and alternate structure at each buffer end.
// RULE_10: Memory scatter/gather walks a task list copied into the alternate structure.
// RULE_11: Peripheral scatter/gather walks the list but advances only on request.
// RULE_12: Software aligns the control table base to 1024 bytes.
// RULE_13: The control table spans at most 1024 bytes for all structures.
// RULE_14: Completion clears the channel enable; software can clear it any time.
// RULE_15: Software rewrites the structure and re-enables before each transfer.
// RULE_16: The stored remaining count reads zero after completion.
// RULE_17: Completion writes the stopped mode into the structure.
// RULE_18: A completion raises an interrupt.
// RULE_19: Peripheral completions go to per-channel lines; engine irq for software and errors.
// RULE_20: Completion signals are pulses that need no acknowledge.
// RULE_21: Error status and its interrupt hold until software clears them.
// RULE_22: Basic and auto use the primary structure; alternate only for complex modes.
// RULE_23: A set request mask makes the channel ignore its peripheral request.
// RULE_24: A set burst-only attribute makes the channel ignore single requests.
// RULE_25: The count is decremented per item and written back to the structure.
// RULE_26: At equal priority the lowest-numbered pending channel wins.
module dmae_engine (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [dmae_pkg::NCH-1:0] reqBurst,
  input  wire logic [dmae_pkg::NCH-1:0] reqSingle,
  output logic      [dmae_pkg::NCH-1:0] chanDone,
  output logic                       engIrq,
  input  wire logic                  cpuBusy,
  output logic                       memReq,
  output logic                       memWe,
  output logic      [31:0]           memAddr,
  output logic      [31:0]           memWdata,
  output logic      [1:0]            memSize,
  input  wire logic [31:0]           memRdata,
  input  wire logic                  memAck,
  input  wire logic                  memErr
);
  import dmae_pkg::*;

  typedef struct packed {
    dmae_state_e st;
    logic        cfgEn;
    logic [21:0] tblBase;
    logic [31:0] enable;
    logic [31:0] swPend;
    logic [31:0] prio;
    logic [31:0] reqMask;
    logic [31:0] burstOnly;
    logic [31:0] altSel;
    logic        errFlag;
    logic [4:0]  ch;
    logic        chSw;
    logic        alt;
    logic [31:0] src;
    logic [31:0] dst;
    logic [9:0]  cnt;
    logic [2:0]  mode;
    logic [1:0]  size;
    logic [1:0]  sInc;
    logic [1:0]  dInc;
    logic        sgPrim;
    logic [1:0]  itemCnt;
    logic        fin;
    logic [31:0] data;
    logic        memReq;
    logic        memWe;
    logic [31:0] memAddr;
    logic [31:0] memWdata;
    logic [1:0]  memSize;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] chanDone;
    logic        engIrq;
  } dmae_state_s;

  dmae_state_s s_ff;
  dmae_state_s nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] firstSet(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] stepOf(input logic [1:0] code);
    return (code == INC_NONE) ? 32'h0 : (32'h1 << code);
  endfunction

  // Moves the item from its source byte lane to its destination byte lane
  function automatic logic [31:0] laneMove(input logic [31:0] d, input logic [1:0] sLane,
                                           input logic [1:0] dLane);
    logic [31:0] t;
    t = d >> {sLane, 3'h0};
    return t << {dLane, 3'h0};
  endfunction

  function automatic logic [31:0] packCtl(input logic [2:0] m, input logic [9:0] c,
                                          input logic [1:0] sz, input logic [1:0] si,
                                          input logic [1:0] di);
    logic [31:0] w;
    w = 32'h0;
    w[CTL_MODE_LSB +: 3] = m;
    w[CTL_CNT_LSB +: 10] = c;
    w[CTL_SIZE_LSB +: 2] = sz;
    w[CTL_SINC_LSB +: 2] = si;
    w[CTL_DINC_LSB +: 2] = di;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] hwReq;
  logic [31:0] pend;
  logic [5:0]  hiPick;
  logic [5:0]  loPick;
  logic [31:0] busAddr;
  logic [31:0] busWdata;
  logic        busWe;
  logic        busUse;
  logic        needReq;
  logic [31:0] rdVal;
  logic        mapped;

  // Reserved software channel has no peripheral behind it
  assign hwReq  = (reqBurst | (reqSingle & ~s_ff.burstOnly)) & ~s_ff.reqMask
                  & ~(32'h1 << SW_CH); // [RULE_23] [RULE_24] [RULE_05]
  assign pend   = s_ff.enable & (s_ff.swPend | hwReq) & {NCH{s_ff.cfgEn}}; // [RULE_06]
  assign hiPick = firstSet(pend & s_ff.prio); // [RULE_03] [RULE_26]
  assign loPick = firstSet(pend & ~s_ff.prio); // [RULE_26]
  assign needReq = !s_ff.chSw && (s_ff.mode == M_BASIC || s_ff.mode == M_PSG
                   || s_ff.mode == M_PSG_ALT); // [RULE_07] [RULE_11]

  always_comb begin
    busUse   = 1'b1;
    busWe    = 1'b0;
    busWdata = 32'h0;
    busAddr  = {s_ff.tblBase, s_ff.alt, s_ff.ch, W_SRC, 2'h0}; // [RULE_13]
    unique case (s_ff.st)
      S_LDDST: busAddr[3:2] = W_DST;
      S_LDCTL: busAddr[3:2] = W_CTL;
      S_RDIT:  busAddr = s_ff.src;
      S_WRIT: begin
        busAddr  = s_ff.dst;
        busWe    = 1'b1;
        busWdata = s_ff.data;
      end
      S_WBSRC: begin
        busWe    = 1'b1;
        busWdata = s_ff.src;
      end
      S_WBDST: begin
        busAddr[3:2] = W_DST;
        busWe        = 1'b1;
        busWdata     = s_ff.dst;
      end
      S_WBCTL: begin
        busAddr[3:2] = W_CTL;
        busWe        = 1'b1;
        busWdata     = packCtl((s_ff.fin && !s_ff.sgPrim) ? M_STOP : s_ff.mode, s_ff.cnt,
                               s_ff.size, s_ff.sInc, s_ff.dInc); // [RULE_16] [RULE_17] [RULE_25]
      end
      S_LDSRC: busAddr[3:2] = W_SRC;
      default: busUse = 1'b0;
    endcase
  end

  always_comb begin
    mapped = 1'b1;
    rdVal  = 32'h0;
    unique case (paddr)
      OFF_CFG:     rdVal = {31'h0, s_ff.cfgEn};
      OFF_BASE:    rdVal = {s_ff.tblBase, 10'h0};
      OFF_ENA_SET: rdVal = s_ff.enable;
      OFF_ENA_CLR: rdVal = s_ff.enable;
      OFF_SWREQ:   rdVal = s_ff.swPend;
      OFF_PRIO:    rdVal = s_ff.prio;
      OFF_REQMASK: rdVal = s_ff.reqMask;
      OFF_BURST:   rdVal = s_ff.burstOnly;
      OFF_ALTSEL:  rdVal = s_ff.altSel;
      OFF_ERR:     rdVal = {31'h0, s_ff.errFlag};
      OFF_STAT:    rdVal = {26'h0, s_ff.ch, s_ff.st != S_IDLE};
      default:     mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        acked;
    logic        errSet;
    logic        swDone;
    logic        complete;
    logic [9:0]  cntDec;
    logic [31:0] ctl;
    acked    = 1'b0;
    errSet   = 1'b0;
    swDone   = 1'b0;
    complete = 1'b0;
    cntDec   = s_ff.cnt - 10'h1;
    ctl      = memRdata;
    nxt_s          = s_ff;
    nxt_s.chanDone = 32'h0;

    // Bus master side; a new access waits while the processor owns the bus
    if (busUse) begin
      if (!s_ff.memReq) begin
        if (!cpuBusy) begin // [RULE_04]
          nxt_s.memReq   = 1'b1;
          nxt_s.memWe    = busWe;
          nxt_s.memAddr  = busAddr;
          nxt_s.memWdata = busWdata;
          nxt_s.memSize  = (s_ff.st == S_RDIT || s_ff.st == S_WRIT) ? s_ff.size : SZ_WORD; // [RULE_01]
        end
      end else if (memAck) begin
        nxt_s.memReq = 1'b0;
        acked        = !memErr;
        if (memErr) begin
          errSet                = 1'b1;
          nxt_s.enable[s_ff.ch] = 1'b0;
          nxt_s.st              = S_IDLE;
        end
      end
    end

    unique case (s_ff.st)
      S_IDLE: begin
        if (hiPick[5] || loPick[5]) begin
          nxt_s.ch             = hiPick[5] ? hiPick[4:0] : loPick[4:0]; // [RULE_03]
          nxt_s.chSw           = s_ff.swPend[nxt_s.ch];
          nxt_s.swPend[nxt_s.ch] = 1'b0;
          nxt_s.alt            = s_ff.altSel[nxt_s.ch];
          nxt_s.st             = S_LDSRC;
        end
      end
      S_LDSRC: if (acked) begin
        nxt_s.src = memRdata;
        nxt_s.st  = S_LDDST;
      end
      S_LDDST: if (acked) begin
        nxt_s.dst = memRdata;
        nxt_s.st  = S_LDCTL;
      end
      S_LDCTL: if (acked) begin
        nxt_s.mode    = ctl[CTL_MODE_LSB +: 3];
        nxt_s.cnt     = ctl[CTL_CNT_LSB +: 10];
        nxt_s.size    = ctl[CTL_SIZE_LSB +: 2];
        nxt_s.sInc    = ctl[CTL_SINC_LSB +: 2];
        nxt_s.dInc    = ctl[CTL_DINC_LSB +: 2];
        nxt_s.sgPrim  = !s_ff.alt && (nxt_s.mode == M_MSG || nxt_s.mode == M_PSG);
        nxt_s.itemCnt = 2'h0;
        nxt_s.fin     = 1'b0;
        nxt_s.st      = S_RDIT;
        if (nxt_s.sgPrim) begin
          // Task copy: four words from the list into the alternate structure
          nxt_s.dst  = {s_ff.tblBase, 1'b1, s_ff.ch, 4'h0}; // [RULE_10] [RULE_11]
          nxt_s.size = SZ_WORD;
          nxt_s.sInc = INC_WORD;
          nxt_s.dInc = INC_WORD;
        end
        if (nxt_s.mode == M_STOP || nxt_s.cnt == 10'h0) begin
          nxt_s.enable[s_ff.ch] = 1'b0;
          nxt_s.altSel[s_ff.ch] = 1'b0;
          complete              = nxt_s.sgPrim;
          nxt_s.st              = S_IDLE;
        end
      end
      S_RDIT: if (acked) begin
        nxt_s.data = laneMove(memRdata, s_ff.src[1:0], s_ff.dst[1:0]);
        nxt_s.st   = S_WRIT;
      end
      S_WRIT: if (acked) begin
        nxt_s.src     = s_ff.src + stepOf(s_ff.sInc); // [RULE_02]
        nxt_s.dst     = s_ff.dst + stepOf(s_ff.dInc); // [RULE_02]
        nxt_s.cnt     = cntDec; // [RULE_25]
        nxt_s.itemCnt = s_ff.itemCnt + 2'h1;
        nxt_s.fin     = cntDec == 10'h0;
        if (cntDec == 10'h0 || (s_ff.sgPrim && s_ff.itemCnt == SG_LAST_ITEM)) begin
          nxt_s.st = S_WBSRC;
        end else if (needReq && !hwReq[s_ff.ch]) begin
          nxt_s.st = S_WBSRC; // [RULE_07] [RULE_11]
        end else begin
          nxt_s.st = S_RDIT; // [RULE_08]
        end
      end
      S_WBSRC: if (acked) nxt_s.st = S_WBDST;
      S_WBDST: if (acked) nxt_s.st = S_WBCTL;
      S_WBCTL: if (acked) nxt_s.st = S_FIN;
      S_FIN: begin
        nxt_s.st = S_IDLE;
        if (s_ff.sgPrim) begin
          nxt_s.altSel[s_ff.ch] = 1'b1; // [RULE_10]
        end else if (s_ff.fin) begin
          unique case (s_ff.mode)
            M_PINGPONG: begin
              // Other buffer stopped means the stream ends at its load
              nxt_s.altSel[s_ff.ch] = !s_ff.alt; // [RULE_09]
              complete              = 1'b1;
            end
            M_MSG_ALT, M_PSG_ALT: nxt_s.altSel[s_ff.ch] = 1'b0;
            default: begin
              nxt_s.enable[s_ff.ch] = 1'b0; // [RULE_14]
              nxt_s.altSel[s_ff.ch] = 1'b0; // [RULE_22]
              complete              = 1'b1;
            end
          endcase
        end
      end
      default: nxt_s.st = S_IDLE;
    endcase

    if (complete) begin
      if (s_ff.chSw) begin
        swDone = 1'b1; // [RULE_18] [RULE_19]
      end else begin
        nxt_s.chanDone[s_ff.ch] = 1'b1; // [RULE_19] [RULE_20]
      end
    end

    // APB slave, one wait state; writes land on the edge with pready high
    nxt_s.pready  = psel && penable && !s_ff.pready;
    nxt_s.pslverr = nxt_s.pready && !mapped;
    nxt_s.prdata  = (nxt_s.pready && !pwrite) ? rdVal : 32'h0;
    if (psel && penable && s_ff.pready && pwrite) begin
      unique case (paddr)
        OFF_CFG:     nxt_s.cfgEn = pwdata[0];
        OFF_BASE:    nxt_s.tblBase = pwdata[31:TBL_LSB]; // [RULE_12]
        OFF_ENA_SET: nxt_s.enable = nxt_s.enable | pwdata;
        OFF_ENA_CLR: nxt_s.enable = nxt_s.enable & ~pwdata; // [RULE_14]
        OFF_SWREQ:   nxt_s.swPend = nxt_s.swPend | pwdata; // [RULE_06]
        OFF_PRIO:    nxt_s.prio = pwdata;
        OFF_REQMASK: nxt_s.reqMask = pwdata;
        OFF_BURST:   nxt_s.burstOnly = pwdata;
        OFF_ALTSEL:  nxt_s.altSel = pwdata;
        OFF_ERR:     if (pwdata[0]) nxt_s.errFlag = 1'b0;
        default:     nxt_s.cfgEn = s_ff.cfgEn;
      endcase
    end
    // A new error beats a clear in the same cycle
    if (errSet) nxt_s.errFlag = 1'b1; // [RULE_21]
    nxt_s.engIrq = nxt_s.errFlag || swDone; // [RULE_21]
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata   = s_ff.prdata;
  assign pready   = s_ff.pready;
  assign pslverr  = s_ff.pslverr;
  assign chanDone = s_ff.chanDone;
  assign engIrq   = s_ff.engIrq;
  assign memReq   = s_ff.memReq;
  assign memWe    = s_ff.memWe;
  assign memAddr  = s_ff.memAddr;
  assign memWdata = s_ff.memWdata;
  assign memSize  = s_ff.memSize;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic itemAck;
  assign itemAck = s_ff.st == S_WRIT && memReq && memAck && !memErr;

  sequence wbStart;
    s_ff.st == S_WBSRC && memReq && memAck && !memErr;
  endsequence
  sequence wbCtlNext;
    s_ff.st == S_WBDST ##[1:1000] (s_ff.st == S_WBCTL);
  endsequence

  itemDec_a: assert property (itemAck |=> s_ff.cnt == $past(s_ff.cnt) - 10'h1) // [RULE_25]
    else $error("count not decremented after item");
  fixedAddr_a: assert property (itemAck && s_ff.sInc == INC_NONE |=> $stable(s_ff.src)) // [RULE_02]
    else $error("fixed source address moved");
  cpuYield_a: assert property ($rose(memReq) |-> !$past(cpuBusy)) // [RULE_04]
    else $error("access started while processor held bus");
  hiPrio_a: assert property (s_ff.st == S_IDLE && hiPick[5] |=> s_ff.ch == $past(hiPick[4:0])) // [RULE_03]
    else $error("high priority channel not granted");
  loOrder_a: assert property (s_ff.st == S_IDLE && !hiPick[5] && loPick[5]
                              |=> s_ff.ch == $past(loPick[4:0])) // [RULE_26]
    else $error("lowest pending channel not granted");
  stopWrite_a: assert property (s_ff.st == S_WBCTL && memReq && memWe && s_ff.fin && !s_ff.sgPrim
                                |-> memWdata[CTL_MODE_LSB +: 3] == M_STOP
                                    && memWdata[CTL_CNT_LSB +: 10] == 10'h0) // [RULE_16] [RULE_17]
    else $error("completed structure not stopped");
  autoDone_a: assert property (s_ff.st == S_FIN && s_ff.fin && !s_ff.sgPrim && s_ff.mode == M_AUTO
                               |=> !s_ff.enable[$past(s_ff.ch)]
                                   && (engIrq || chanDone[$past(s_ff.ch)])) // [RULE_14] [RULE_18]
    else $error("auto completion not ended or signalled");
  errHold_a: assert property (s_ff.errFlag && !(psel && penable && pready && pwrite
                              && paddr == OFF_ERR && pwdata[0]) |=> s_ff.errFlag && engIrq) // [RULE_21]
    else $error("error status dropped without clear");
  basicPause_a: assert property (itemAck && s_ff.mode == M_BASIC && !s_ff.chSw && s_ff.cnt > 10'h1
                                 && !hwReq[s_ff.ch] |=> s_ff.st == S_WBSRC) // [RULE_07]
    else $error("basic mode ran without request");
  wbOrder_a: assert property (wbStart |=> wbCtlNext) // [RULE_25]
    else $error("writeback sequence broken");
endmodule

// >>> dv/dmae_mem_model.sv
`timescale 1ns/1ps
module dmae_mem_model (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [1:0]  memSize,
  input  wire logic [2:0]  dly,
  input  wire logic        errOn,
  output logic      [31:0] memRdata,
  output logic             memAck,
  output logic             memErr
);
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [2:0]  cnt;
    logic [31:0] rd;
  } dmae_mm_s;
  dmae_mm_s    st_ff;
  dmae_mm_s    nxt_st;
  logic [31:0] mem [0:1023];
  logic [3:0]  be;
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.err = 1'b0;
    // Idle data toggles so a stale read is never mistaken for a good one
    nxt_st.rd = ~st_ff.rd;
    if (memReq && !st_ff.ack) begin
      if (st_ff.cnt >= dly) begin
        nxt_st.ack = 1'b1;
        nxt_st.err = errOn;
        nxt_st.rd = mem[memAddr[11:2]];
        nxt_st.cnt = 3'h0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 3'h1;
      end
    end
    case (memSize)
      2'h0:    be = 4'h1 << memAddr[1:0];
      2'h1:    be = memAddr[1] ? 4'hC : 4'h3;
      default: be = 4'hF;
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // Plain always: the bench also preloads this array
  always @(posedge core_clk) begin
    if (memReq && memWe && nxt_st.ack && !errOn) begin
      for (int b = 0; b < 4; b++) begin
        if (be[b]) begin
          mem[memAddr[11:2]][8*b +: 8] <= memWdata[8*b +: 8];
        end
      end
    end
  end
  assign memRdata = st_ff.rd;
  assign memAck   = st_ff.ack;
  assign memErr   = st_ff.err;
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  import dmae_pkg::*;
  localparam logic [31:0] BASE = 32'h0000_0400;
  logic           core_clk, nrst, psel, penable, pwrite, pready, pslverr, engIrq, cpuBusy;
  logic           memReq, memWe, memAck, memErr, errOn, prevReq, prevBusy, arm, irqSeen, rdErr;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, memAddr, memWdata, memRdata, rd, firstA, s, d;
  logic [NCH-1:0] reqBurst, reqSingle, chanDone;
  logic [1:0]     memSize;
  logic [2:0]     dly;
  logic [15:0]    lf, rs;
  int             mismatches, n_compared, k, t;
  dmae_engine i_dmae_engine (.core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reqBurst(reqBurst), .reqSingle(reqSingle), .chanDone(chanDone),
    .engIrq(engIrq), .cpuBusy(cpuBusy), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memSize(memSize), .memRdata(memRdata), .memAck(memAck),
    .memErr(memErr));
  dmae_mem_model i_mem (.core_clk(core_clk), .nrst(nrst), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize), .dly(dly), .errOn(errOn),
    .memRdata(memRdata), .memAck(memAck), .memErr(memErr));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] byt(input logic [31:0] a);
    return i_mem.mem[a[11:2]][8*a[1:0] +: 8];
  endfunction
  function automatic logic [9:0] cntOf(input int ch);
    return i_mem.mem[(BASE + ch*16 + 8) >> 2][CTL_CNT_LSB +: 10];
  endfunction
  function automatic logic [2:0] modeOf(input int ch);
    return i_mem.mem[(BASE + ch*16 + 8) >> 2][CTL_MODE_LSB +: 3];
  endfunction
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic setup(input int ch, input logic [31:0] sa, input logic [31:0] da,
                       input logic [2:0] m, input int n, input logic [1:0] sz,
                       input logic [1:0] inc);
    int i;
    i = (BASE + ch*16) >> 2;
    i_mem.mem[i] = sa;
    i_mem.mem[i+1] = da;
    i_mem.mem[i+2] = {10'h0, inc, inc, sz, 2'h0, n[9:0], 1'b0, m};
  endtask
  task automatic waitEv(input int ch);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((ch < 0 ? engIrq : chanDone[ch]) !== 1'b1 && n < 4000);
    chk(n < 4000, "no completion");
  endtask
  task automatic endChk(input int ch);
    chk(cntOf(ch) === 10'h0, "count not zero");
    chk(modeOf(ch) === M_STOP, "mode not stopped");
    apb(1'b0, OFF_ENA_SET, 32'h0);
    chk(rd[ch] === 1'b0, "channel still enabled");
  endtask
  task automatic cmp(input logic [31:0] sa, input logic [31:0] da, input int n,
                     input logic [1:0] sz, input logic [1:0] inc);
    int j, b, st;
    st = (inc == INC_NONE) ? 0 : (1 << inc);
    for (j = 0; j < n; j++) begin
      for (b = 0; b < (1 << sz); b++) begin
        chk(byt(da + j*st + b) === byt(sa + j*st + b), "data moved wrong");
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #5_000_000;
    mismatches++;
    wrap_up();
  end
  // Random processor traffic and memory latency
  always @(posedge core_clk) begin
    lf <= nx(lf);
    cpuBusy <= (lf[2:0] == 3'h0);
    dly <= lf[5:3];
  end
  always @(posedge core_clk) begin
    if (memReq && !prevReq && prevBusy) chk(1'b0, "access began while cpu busy");
    if (memReq && memAddr[31:9] === {BASE[31:10], 1'b1}) chk(1'b0, "alternate used");
    if (arm && memReq && !prevReq) begin
      firstA <= memAddr;
      arm <= 1'b0;
    end
    if (engIrq === 1'b1) irqSeen <= 1'b1;
    prevReq <= memReq;
    prevBusy <= cpuBusy;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, reqBurst, reqSingle, errOn, arm, irqSeen} = '0;
    {cpuBusy, dly, prevReq, prevBusy} = '0;
    lf = 16'h55;
    rs = 16'h55;
    nrst = 1'b0;
    for (k = 64; k < 256; k++) begin
      rs = nx(rs);
      i_mem.mem[k] = {rs, ~rs};
      i_mem.mem[k+512] = ~{rs, ~rs};
    end
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    apb(1'b1, OFF_CFG, 32'h1);
    apb(1'b1, OFF_BASE, BASE);
    apb(1'b0, OFF_BASE, 32'h0);
    chk(rd === BASE, "base readback");
    apb(1'b0, 12'h100, 32'h0);
    chk(rdErr === 1'b1 && rd === 32'h0, "unmapped access");
    apb(1'b1, OFF_ENA_SET, 32'h80);
    apb(1'b1, OFF_ENA_CLR, 32'h80);
    apb(1'b0, OFF_ENA_SET, 32'h0);
    chk(rd[7] === 1'b0, "disable on command");
    for (k = 0; k < 4; k++) begin
      s = 32'h100 + k*64 + (k == 0);
      d = 32'h900 + k*64 + 3*(k == 0);
      t = 1 + rs[2:0];
      rs = nx(rs);
      setup(SW_CH, s, d, k[0] ? M_BASIC : M_AUTO, t, (k == 3) ? SZ_WORD : k[1:0], k[1:0]);
      apb(1'b1, OFF_ENA_SET, 32'h1 << SW_CH);
      apb(1'b1, OFF_SWREQ, 32'h1 << SW_CH);
      waitEv(-1);
      endChk(SW_CH);
      cmp(s, d, t, (k == 3) ? SZ_WORD : k[1:0], k[1:0]);
      if (k == 3) chk(i_mem.mem[(d>>2)+1] === ~i_mem.mem[(s>>2)+1], "fixed dst moved");
    end
    setup(2, 32'h200, 32'hA00, M_BASIC, 8, SZ_WORD, INC_WORD);
    apb(1'b1, OFF_REQMASK, 32'h4);
    apb(1'b1, OFF_BURST, 32'h4);
    apb(1'b1, OFF_ENA_SET, 32'h4);
    reqBurst <= 32'h4;
    repeat (60) @(posedge core_clk);
    chk(cntOf(2) === 10'h8, "masked request served");
    reqBurst <= '0;
    reqSingle <= 32'h4;
    apb(1'b1, OFF_REQMASK, 32'h0);
    repeat (60) @(posedge core_clk);
    chk(cntOf(2) === 10'h8, "single request served");
    reqSingle <= '0;
    reqBurst <= 32'h4;
    irqSeen = 1'b0;
    do @(posedge core_clk);
    while (!(memReq === 1'b1 && memWe === 1'b1 && memAddr === 32'hA00));
    reqBurst <= '0;
    repeat (100) @(posedge core_clk);
    chk(memReq === 1'b0 && cntOf(2) > 0 && cntOf(2) < 8, "no pause");
    reqBurst <= 32'h4;
    waitEv(2);
    reqBurst <= '0;
    chk(irqSeen === 1'b0, "engine irq on peripheral completion");
    endChk(2);
    cmp(32'h200, 32'hA00, 8, SZ_WORD, INC_WORD);
    for (k = 0; k < 2; k++) begin
      setup(3, 32'h300, 32'hB00, M_AUTO, 2, SZ_WORD, INC_WORD);
      setup(5, 32'h340, 32'hB40, M_AUTO, 2, SZ_WORD, INC_WORD);
      apb(1'b1, OFF_ENA_SET, 32'h28);
      apb(1'b1, OFF_PRIO, k ? 32'h20 : 32'h0);
      arm = 1'b1;
      apb(1'b1, OFF_SWREQ, 32'h28);
      waitEv(-1);
      waitEv(-1);
      chk(firstA === BASE + (k ? 32'h50 : 32'h30), "wrong grant order");
    end
    setup(SW_CH, 32'h380, 32'hB80, M_AUTO, 2, SZ_WORD, INC_WORD);
    errOn = 1'b1;
    apb(1'b1, OFF_ENA_SET, 32'h1 << SW_CH);
    apb(1'b1, OFF_SWREQ, 32'h1 << SW_CH);
    waitEv(-1);
    errOn = 1'b0;
    irqSeen = 1'b1;
    repeat (30) begin
      @(posedge core_clk);
      irqSeen = irqSeen & engIrq;
    end
    apb(1'b0, OFF_ERR, 32'h0);
    chk(irqSeen === 1'b1 && rd[0] === 1'b1, "error not held");
    apb(1'b1, OFF_ERR, 32'h1);
    @(posedge core_clk);
    chk(engIrq === 1'b0, "error irq not cleared");
    wrap_up();
  end
endmodule
